// >>> lcdc_pkg.sv
// Constants, types and field layout of the LCD driver control register bank
// Function
// - Segment order bit D7: 1 normal, 0 reversed; resets to 1.
// - Common order bit D6: 1 normal, 0 reversed; resets to 1.
// - Memory area bit D5: 1 fetches area 1, 0 area 0; resets 0.
// - Heavy-load protection bit D4 of regulator control: 1 on; resets off.
// - Regulator source bit D1 of power register selects secondary supply; resets 0.
// - Booster bit D0 of power register: 1 on, 0 off; resets off.
// - Frame interrupt enable D0 of mask register gates requests; resets disabled.
// - Frame event sets flag D0; writing 1 clears it, 0 keeps; resets 0.
package lcdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          ADDR_W   = 18;
  localparam int          DATA_W   = 32;
  localparam int          REG_W    = 8;
  localparam int          IDX_W    = 16;
  localparam int          IRQ_N    = 1;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DISPLAY_CONTROL = 16'h50a0;
  localparam logic [IDX_W-1:0] IDX_CONTRAST_ADJUST = 16'h50a1;
  localparam logic [IDX_W-1:0] IDX_DUTY_SELECT     = 16'h50a2;
  localparam logic [IDX_W-1:0] IDX_REGULATOR_CTRL  = 16'h50a3;
  localparam logic [IDX_W-1:0] IDX_POWER_BOOSTER   = 16'h50a4;
  localparam logic [IDX_W-1:0] IDX_INTERRUPT_MASK  = 16'h50a5;
  localparam logic [IDX_W-1:0] IDX_INTERRUPT_FLAG  = 16'h50a6;
  localparam logic [IDX_W-1:0] IDX_INTERRUPT_CLEAR = 16'h50a7;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int DCTL_SEG_BIT   = 7;
  localparam int DCTL_COM_BIT   = 6;
  localparam int DCTL_AREA_BIT  = 5;
  localparam int DCTL_REV_BIT   = 4;
  localparam int DCTL_MODE_LSB  = 0;
  localparam int CADJ_LVL_LSB   = 0;
  localparam int CCTL_DUTY_LSB  = 0;
  localparam int VREG_HVLD_BIT  = 4;
  localparam int PWR_REGULATOR_SOURCE_SELECT_BIT  = 1;
  localparam int PWR_BOOSTER_ON_BIT   = 0;
  localparam int IRQ_FRAME_BIT  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [REG_W-1:0] RST_DISPLAY_CONTROL = 8'hd0;
  localparam logic [REG_W-1:0] RST_CONTRAST_ADJUST = 8'h00;
  localparam logic [REG_W-1:0] RST_DUTY_SELECT     = 8'h02;
  localparam logic [REG_W-1:0] RST_REGULATOR_CTRL  = 8'h00;
  localparam logic [REG_W-1:0] RST_POWER_BOOSTER   = 8'h00;
  localparam logic [REG_W-1:0] RST_INTERRUPT_MASK  = 8'h00;
  localparam logic [REG_W-1:0] RST_INTERRUPT_FLAG  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Implemented bits per register; the rest are reserved
  localparam logic [REG_W-1:0] MSK_DISPLAY_CONTROL = 8'hf3;
  localparam logic [REG_W-1:0] MSK_CONTRAST_ADJUST = 8'h0f;
  localparam logic [REG_W-1:0] MSK_DUTY_SELECT     = 8'h03;
  localparam logic [REG_W-1:0] MSK_REGULATOR_CTRL  = 8'h10;
  localparam logic [REG_W-1:0] MSK_POWER_BOOSTER   = 8'h03;
  localparam logic [REG_W-1:0] MSK_INTERRUPT       = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Modes
  typedef enum logic [1:0] {
    LCDC_DISP_OFF,
    LCDC_DISP_NORMAL,
    LCDC_DISP_ALL_ON,
    LCDC_DISP_ALL_OFF
  } lcdc_dmode_e;

  typedef enum logic [1:0] {
    LCDC_DUTY_RSVD0,
    LCDC_DUTY_1_16,
    LCDC_DUTY_1_32,
    LCDC_DUTY_RSVD3
  } lcdc_duty_e;

  // Settings handed to the segment/common drive logic
  typedef struct packed {
    logic        segment_order_normal;
    logic        common_order_normal;
    logic        memory_area_select;
    logic        reverse_display_normal;
    lcdc_dmode_e display_mode;
    logic [3:0]  contrast_level;
    lcdc_duty_e  duty_select;
    logic        heavy_load_protect;
    logic        regulator_source_select;
    logic        booster_on;
  } lcdc_ctrl_s;

endpackage

// >>> lcdc_sync3.sv
// Three-stage synchroniser with agreement filter and edge pulse
`timescale 1ns/100ps
module lcdc_sync3
  import lcdc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise
);

  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_q;
  logic       lvl_d;
  logic       rise_q;
  logic       rise_d;

  // Stage one only feeds stage two; the level moves once two and three agree
  always_comb begin
    sh_d   = {sh_q[1:0], i_async};
    lvl_d  = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
    rise_d = lvl_d & ~lvl_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sh_q   <= 3'h0;
      lvl_q  <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      sh_q   <= sh_d;
      lvl_q  <= lvl_d;
      rise_q <= rise_d;
    end
  end

  assign o_level = lvl_q;
  assign o_rise  = rise_q;

endmodule

// >>> lcdc_irq.sv
// Sticky interrupt status bits, enable gating and the level request
`timescale 1ns/100ps
module lcdc_irq
  import lcdc_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [IRQ_N-1:0] i_set,
  input  wire logic [IRQ_N-1:0] i_clr,
  input  wire logic [IRQ_N-1:0] i_en,
  output logic      [IRQ_N-1:0] o_status,
  output logic                  o_irq
);

  logic [IRQ_N-1:0] stat_q;
  logic [IRQ_N-1:0] stat_d;
  logic             irq_q;
  logic             irq_d;

  // Set beats clear, so an event in the clearing cycle survives
  for (genvar g = 0; g < IRQ_N; g++) begin : g_bit
    assign stat_d[g] = i_set[g] | (stat_q[g] & ~i_clr[g]);
  end

  // Request from next state so it lines up with the flag it reports
  always_comb begin
    irq_d = |(stat_d & i_en);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= irq_d;
    end
  end

  assign o_status = stat_q;
  assign o_irq    = irq_q;

endmodule

// >>> lcdc_regs.sv
// LCD driver control register bank on an Avalon-MM slave port
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
module lcdc_regs
  import lcdc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  input  wire logic              i_frame_sig,
  output logic      [DATA_W-1:0] o_avs_readdata,
  output logic                   o_avs_waitrequest,
  output logic      [1:0]        o_avs_response,
  output lcdc_ctrl_s             o_ctrl,
  output logic                   o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Bus handshake state
  logic              wait_q;
  logic              wait_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [1:0]        resp_q;
  logic [1:0]        resp_d;

  // Storage registers, reserved bits held at zero
  logic [REG_W-1:0]  dctl_q;
  logic [REG_W-1:0]  dctl_d;
  logic [REG_W-1:0]  cadj_q;
  logic [REG_W-1:0]  cadj_d;
  logic [REG_W-1:0]  cctl_q;
  logic [REG_W-1:0]  cctl_d;
  logic [REG_W-1:0]  vreg_q;
  logic [REG_W-1:0]  vreg_d;
  logic [REG_W-1:0]  pwr_q;
  logic [REG_W-1:0]  pwr_d;
  logic [REG_W-1:0]  imsk_q;
  logic [REG_W-1:0]  imsk_d;

  // Decode results
  // The index drops the two lane bits of the byte address
  logic [IDX_W-1:0]  idx;
  logic              req;
  logic              take;
  logic              capture;
  logic              lane0;
  logic [REG_W-1:0]  wbyte;
  logic              hit_dctl;
  logic              hit_cadj;
  logic              hit_cctl;
  logic              hit_vreg;
  logic              hit_pwr;
  logic              hit_imsk;
  logic              hit_iflg;
  logic              hit_iclr;
  logic              hit_any;

  // Write strobes, one per register
  logic              wr_dctl;
  logic              wr_cadj;
  logic              wr_cctl;
  logic              wr_vreg;
  logic              wr_pwr;
  logic              wr_imsk;
  logic              wr_iflg;
  logic              wr_iclr;

  // Event and interrupt wiring
  // Vectors are IRQ_N wide so further events can join later
  logic              frame_rise;
  logic [IRQ_N-1:0]  evt_set;
  logic [IRQ_N-1:0]  evt_clr;
  logic [IRQ_N-1:0]  evt_en;
  logic [IRQ_N-1:0]  evt_stat;
  logic [REG_W-1:0]  rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Index compare only; no wildcard or mirrored regions

  // Word index from the byte address; low two bits are lane bits
  assign idx = i_avs_address[ADDR_W-1:2];

  // One-hot register hits; unmapped indices hit nothing
  always_comb begin
    hit_dctl = 1'b0;
    hit_cadj = 1'b0;
    hit_cctl = 1'b0;
    hit_vreg = 1'b0;
    hit_pwr  = 1'b0;
    hit_imsk = 1'b0;
    hit_iflg = 1'b0;
    hit_iclr = 1'b0;
    if (idx == IDX_DISPLAY_CONTROL) begin
      hit_dctl = 1'b1;
    end else if (idx == IDX_CONTRAST_ADJUST) begin
      hit_cadj = 1'b1;
    end else if (idx == IDX_DUTY_SELECT) begin
      hit_cctl = 1'b1;
    end else if (idx == IDX_REGULATOR_CTRL) begin
      hit_vreg = 1'b1;
    end else if (idx == IDX_POWER_BOOSTER) begin
      hit_pwr = 1'b1;
    end else if (idx == IDX_INTERRUPT_MASK) begin
      hit_imsk = 1'b1;
    end else if (idx == IDX_INTERRUPT_FLAG) begin
      hit_iflg = 1'b1;
    end else if (idx == IDX_INTERRUPT_CLEAR) begin
      hit_iclr = 1'b1;
    end
    hit_any = hit_dctl | hit_cadj | hit_cctl | hit_vreg
            | hit_pwr | hit_imsk | hit_iflg | hit_iclr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon handshake
  // One wait state for every access, read or write alike

  // Fixed two-edge answer: first edge captures, second edge completes.
  // Waitrequest comes from a flop, which costs one cycle per access
  // but keeps the bus output free of decode glitches.
  // A master that drops its request early finds waitrequest high again;
  // nothing is written, since take needs the request still up.
  always_comb begin
    req     = i_avs_read | i_avs_write;
    capture = req & wait_q;
    take    = req & ~wait_q;
    wait_d  = ~capture;
    lane0   = i_avs_byteenable[0];
    wbyte   = i_avs_writedata[REG_W-1:0];
  end

  // Write strobes fire only at the completing edge and with lane 0 on
  // Lanes 1 to 3 carry nothing; a write without lane 0 still completes
  // on the bus but leaves every register untouched
  always_comb begin
    wr_dctl = take & i_avs_write & lane0 & hit_dctl;
    wr_cadj = take & i_avs_write & lane0 & hit_cadj;
    wr_cctl = take & i_avs_write & lane0 & hit_cctl;
    wr_vreg = take & i_avs_write & lane0 & hit_vreg;
    wr_pwr  = take & i_avs_write & lane0 & hit_pwr;
    wr_imsk = take & i_avs_write & lane0 & hit_imsk;
    wr_iflg = take & i_avs_write & lane0 & hit_iflg;
    wr_iclr = take & i_avs_write & lane0 & hit_iclr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register next values
  // Each register has its own next-value process; writes never merge

  // Display control: order, area, reverse and mode fields
  always_comb begin
    dctl_d = dctl_q;
    if (wr_dctl) begin
      dctl_d = wbyte & MSK_DISPLAY_CONTROL;
    end
  end

  // Contrast level, sixteen steps light to dark
  always_comb begin
    cadj_d = cadj_q;
    if (wr_cadj) begin
      cadj_d = wbyte & MSK_CONTRAST_ADJUST;
    end
  end

  // Duty; reserved codes are stored as written, drive logic must cope
  always_comb begin
    cctl_d = cctl_q;
    if (wr_cctl) begin
      cctl_d = wbyte & MSK_DUTY_SELECT;
    end
  end

  // Regulator control: heavy-load protection only
  always_comb begin
    vreg_d = vreg_q;
    if (wr_vreg) begin
      vreg_d = wbyte & MSK_REGULATOR_CTRL;
    end
  end

  // Power: regulator source and booster switch
  always_comb begin
    pwr_d = pwr_q;
    if (wr_pwr) begin
      pwr_d = wbyte & MSK_POWER_BOOSTER;
    end
  end

  // Interrupt enable
  always_comb begin
    imsk_d = imsk_q;
    if (wr_imsk) begin
      imsk_d = wbyte & MSK_INTERRUPT;
    end
  end

  // Storage, all values defined from reset
  // Reserved bits are masked on the way in, so reset and storage agree
  // and the read path needs no second mask
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dctl_q <= RST_DISPLAY_CONTROL;
      cadj_q <= RST_CONTRAST_ADJUST;
      cctl_q <= RST_DUTY_SELECT;
      vreg_q <= RST_REGULATOR_CTRL;
      pwr_q  <= RST_POWER_BOOSTER;
      imsk_q <= RST_INTERRUPT_MASK;
    end else begin
      dctl_q <= dctl_d;
      cadj_q <= cadj_d;
      cctl_q <= cctl_d;
      vreg_q <= vreg_d;
      pwr_q  <= pwr_d;
      imsk_q <= imsk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame event and interrupt
  // Event enters here, status leaves through the read path

  // Frame signal comes from the slower LCD clock, so it is synchronised
  // The filter adds about four cycles per event, harmless against a frame
  // period; the level output is unused, only the rising edge is an event
  // A pulse shorter than two clock cycles may be missed entirely
  lcdc_sync3 u_frame_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_frame_sig),
    .o_level (),
    .o_rise  (frame_rise)
  );

  // Write one clears, via the flag register or the clear register
  // Software may use either address; the flag register stays readable
  // and writing zero to it changes nothing
  always_comb begin
    evt_set = '0;
    evt_clr = '0;
    evt_en  = imsk_q[IRQ_N-1:0];
    evt_set[IRQ_FRAME_BIT] = frame_rise;
    if (wr_iflg | wr_iclr) begin
      evt_clr = wbyte[IRQ_N-1:0] & MSK_INTERRUPT[IRQ_N-1:0];
    end
  end

  // Sticky flag and level request live in their own small module
  lcdc_irq u_irq (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_set    (evt_set),
    .i_clr    (evt_clr),
    .i_en     (evt_en),
    .o_status (evt_stat),
    .o_irq    (o_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  // Read data comes from the same flops that drive the outputs

  // Byte selected for reading; clear register and unmapped read zero
  // Falling through to zero keeps stale storage off the bus
  // for any place that has nothing to report
  always_comb begin
    rd_byte = 8'h00;
    if (hit_dctl) begin
      rd_byte = dctl_q;
    end else if (hit_cadj) begin
      rd_byte = cadj_q;
    end else if (hit_cctl) begin
      rd_byte = cctl_q;
    end else if (hit_vreg) begin
      rd_byte = vreg_q;
    end else if (hit_pwr) begin
      rd_byte = pwr_q;
    end else if (hit_imsk) begin
      rd_byte = imsk_q;
    end else if (hit_iflg) begin
      rd_byte[IRQ_N-1:0] = evt_stat;
    end
  end

  // Data and response latched at the capturing edge, held until the next
  // access; unmapped addresses answer with a slave error
  // A write returns zero data so readdata never echoes a value
  // the master did not ask for
  always_comb begin
    rdata_d = rdata_q;
    resp_d  = resp_q;
    if (capture) begin
      rdata_d = {{(DATA_W-REG_W){1'b0}}, rd_byte};
      resp_d  = hit_any ? RESP_OK : RESP_ERR;
      if (i_avs_write) begin
        rdata_d = '0;
      end
    end
  end

  // Handshake and answer registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
      resp_q  <= RESP_OK;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      resp_q  <= resp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Every output below is a flop or a bundle of flops

  // Bus answer straight from flops
  // Readdata and response keep their last value between accesses
  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_avs_response    = resp_q;

  // Drive settings straight from the storage flops
  // Reserved duty codes pass through unchanged; the drive logic decides
  // what they mean
  always_comb begin
    o_ctrl.segment_order_normal    = dctl_q[DCTL_SEG_BIT];
    o_ctrl.common_order_normal     = dctl_q[DCTL_COM_BIT];
    o_ctrl.memory_area_select      = dctl_q[DCTL_AREA_BIT];
    o_ctrl.reverse_display_normal  = dctl_q[DCTL_REV_BIT];
    o_ctrl.display_mode            =
      lcdc_dmode_e'(dctl_q[DCTL_MODE_LSB +: 2]);
    o_ctrl.contrast_level          = cadj_q[CADJ_LVL_LSB +: 4];
    o_ctrl.duty_select             =
      lcdc_duty_e'(cctl_q[CCTL_DUTY_LSB +: 2]);
    o_ctrl.heavy_load_protect      = vreg_q[VREG_HVLD_BIT];
    o_ctrl.regulator_source_select = pwr_q[PWR_REGULATOR_SOURCE_SELECT_BIT];
    o_ctrl.booster_on              = pwr_q[PWR_BOOSTER_ON_BIT];
  end

endmodule

// >>> lcdc_regs_monitor.sv
// Port-level assertions for the LCD driver control register bank
`timescale 1ns/100ps
module lcdc_regs_monitor
  import lcdc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  input  wire logic              i_frame_sig,
  input  wire logic [DATA_W-1:0] o_avs_readdata,
  input  wire logic              o_avs_waitrequest,
  input  wire logic [1:0]        o_avs_response,
  input  wire lcdc_ctrl_s        o_ctrl,
  input  wire logic              o_irq
);
  logic             en_q;
  logic             en_d;
  logic [IDX_W-1:0] idx;
  logic             wr_ok;
  logic             rd_ok;
  logic [3:0]       quiet_q;
  logic             fs_q;

  ////////////////////////////////////////////////////////////////////////////
  // Accepted transfers; only the edge with waitrequest low counts
  assign idx   = i_avs_address[17:2];
  assign wr_ok = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  assign rd_ok = i_avs_read & ~o_avs_waitrequest;

  // Shadow of the enable bit, since the real one is not on the ports
  always_comb begin
    en_d = en_q;
    if (wr_ok && idx == IDX_INTERRUPT_MASK) en_d = i_avs_writedata[0];
  end
  always_ff @(posedge i_clk) begin
    en_q <= i_rst ? 1'b0 : en_d;
  end

  // Cycles since the frame pin rose; a set still in the synchroniser beats a clear
  always_ff @(posedge i_clk) begin
    fs_q <= i_frame_sig;
    if (i_rst || (i_frame_sig && !fs_q)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  seg_write_a: assert property (wr_ok && idx == IDX_DISPLAY_CONTROL |=>
    o_ctrl.segment_order_normal == $past(i_avs_writedata[7])) else $error("segment bit");
  com_area_a: assert property (wr_ok && idx == IDX_DISPLAY_CONTROL |=>
    {o_ctrl.common_order_normal, o_ctrl.memory_area_select} == $past(i_avs_writedata[6:5]))
    else $error("common or area bit");
  heavy_load_a: assert property (wr_ok && idx == IDX_REGULATOR_CTRL |=>
    o_ctrl.heavy_load_protect == $past(i_avs_writedata[4])) else $error("protect bit");
  power_bits_a: assert property (wr_ok && idx == IDX_POWER_BOOSTER |=>
    {o_ctrl.regulator_source_select, o_ctrl.booster_on} == $past(i_avs_writedata[1:0]))
    else $error("power bits");
  ctrl_hold_a: assert property (!wr_ok |=> $stable(o_ctrl))
    else $error("control moved without a write");
  irq_off_a: assert property (wr_ok && idx == IDX_INTERRUPT_MASK &&
    !i_avs_writedata[0] |=> ##1 !o_irq) else $error("irq stays after disable");
  flag_clear_a: assert property (wr_ok && i_avs_writedata[0] && quiet_q > 4'h6 &&
    (idx == IDX_INTERRUPT_FLAG || idx == IDX_INTERRUPT_CLEAR) |=> !o_irq)
    else $error("irq stays after clear");
  irq_gate_a: assert property ($rose(o_irq) |-> $past(en_q))
    else $error("irq rose while disabled");
  rsvd_zero_a: assert property (rd_ok && idx == IDX_DISPLAY_CONTROL |->
    (o_avs_readdata & ~{24'h0, MSK_DISPLAY_CONTROL}) == 32'h0) else $error("reserved bits");
  unmapped_read_a: assert property (rd_ok && idx > IDX_INTERRUPT_CLEAR |->
    o_avs_readdata == 32'h0 && o_avs_response == RESP_ERR) else $error("unmapped read");
endmodule

// >>> lcdc_regs_tb.sv
// Self-checking bench for the LCD driver control register bank
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin errors++; \
  $display("BAD %s exp=%0h got=%0h", nm, ex, gt); end end
module lcdc_regs_tb;
  import lcdc_pkg::*;
  logic              i_clk;
  logic              i_rst;
  logic [ADDR_W-1:0] i_avs_address;
  logic              i_avs_read;
  logic              i_avs_write;
  logic [DATA_W-1:0] i_avs_writedata;
  logic [3:0]        i_avs_byteenable;
  logic              i_frame_sig;
  logic [DATA_W-1:0] o_avs_readdata;
  logic              o_avs_waitrequest;
  logic [1:0]        o_avs_response;
  lcdc_ctrl_s        o_ctrl;
  logic              o_irq;
  int                errors;
  int                cmp_count;
  int                cyc;
  logic [33:0]       exp_q[$];
  logic [7:0]        mem [0:4];
  logic [7:0]        msk [0:4];

  lcdc_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .i_frame_sig(i_frame_sig),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_avs_response(o_avs_response), .o_ctrl(o_ctrl), .o_irq(o_irq));

  always #50 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////
  // One Avalon transfer; holds everything until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] ix, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge i_clk);
    i_avs_address    <= {ix, 2'b00};
    i_avs_writedata  <= {d, d, d, d};
    i_avs_byteenable <= be;
    i_avs_write      <= wr;
    i_avs_read       <= ~wr;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask

  // Note the expected answer, then read
  task automatic rd(input logic [15:0] ix, input logic [7:0] ex, input logic [1:0] rsp);
    exp_q.push_back({rsp, 24'h0, ex});
    bus(1'b0, ix, 8'h00, 4'hf);
  endtask

  // Frame pulse long enough to pass the filter, then time to settle
  task automatic frame();
    @(posedge i_clk);
    i_frame_sig <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_frame_sig <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask

  function automatic lcdc_ctrl_s ctrl_of();
    return {mem[0][7:4], mem[0][1:0], mem[1][3:0], mem[2][1:0], mem[3][4], mem[4][1:0]};
  endfunction

  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Read answers are compared against the oldest note
  always @(posedge i_clk) begin
    logic [33:0] e;
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
      e = exp_q.pop_front();
      `CHK("readback", e, {o_avs_response, o_avs_readdata})
    end
  end

  // Hang guard, well above the roughly 480 cycles the run needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("BAD timeout exp=0 got=1");
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [3:0] be;
    int         k;
    i_clk = 1'b0; i_rst = 1'b1; i_avs_address = '0; i_avs_read = 1'b0;
    i_avs_write = 1'b0; i_avs_writedata = '0; i_avs_byteenable = '0; i_frame_sig = 1'b0;
    errors = 0; cmp_count = 0; cyc = 0;
    void'($urandom(32'h9ced8545));
    mem = '{RST_DISPLAY_CONTROL, RST_CONTRAST_ADJUST, RST_DUTY_SELECT, RST_REGULATOR_CTRL,
            RST_POWER_BOOSTER};
    msk = '{MSK_DISPLAY_CONTROL, MSK_CONTRAST_ADJUST, MSK_DUTY_SELECT, MSK_REGULATOR_CTRL,
            MSK_POWER_BOOSTER};
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    // Reset values on the control outputs and in every register
    `CHK("ctrl_reset", ctrl_of(), o_ctrl)
    for (int i = 0; i < 5; i++) rd(IDX_DISPLAY_CONTROL + 16'(i), mem[i], RESP_OK);
    rd(IDX_INTERRUPT_MASK, 8'h00, RESP_OK);
    rd(IDX_INTERRUPT_FLAG, 8'h00, RESP_OK);
    // Random writes; byteenable bit 0 low must leave the register alone
    for (int n = 0; n < 60; n++) begin
      k  = $urandom_range(4);
      d  = 8'($urandom);
      be = 4'($urandom);
      bus(1'b1, IDX_DISPLAY_CONTROL + 16'(k), d, be);
      if (be[0]) mem[k] = d & msk[k];
      rd(IDX_DISPLAY_CONTROL + 16'(k), mem[k], RESP_OK);
      `CHK("ctrl", ctrl_of(), o_ctrl)
    end
    // Unmapped place and the write-only clear register
    bus(1'b1, 16'h50a8, 8'hff, 4'hf);
    rd(16'h50a8, 8'h00, RESP_ERR);
    rd(IDX_INTERRUPT_CLEAR, 8'h00, RESP_OK);
    // Frame event while disabled: flag sets, request stays low
    frame();
    rd(IDX_INTERRUPT_FLAG, 8'h01, RESP_OK);
    `CHK("irq_masked", 1'b0, o_irq)
    bus(1'b1, IDX_INTERRUPT_MASK, 8'h01, 4'hf);
    repeat (3) @(posedge i_clk);
    `CHK("irq_enabled", 1'b1, o_irq)
    // Writing zero keeps the flag, writing one clears it
    bus(1'b1, IDX_INTERRUPT_FLAG, 8'hfe, 4'hf);
    rd(IDX_INTERRUPT_FLAG, 8'h01, RESP_OK);
    `CHK("irq_kept", 1'b1, o_irq)
    bus(1'b1, IDX_INTERRUPT_FLAG, 8'h01, 4'hf);
    rd(IDX_INTERRUPT_FLAG, 8'h00, RESP_OK);
    `CHK("irq_cleared", 1'b0, o_irq)
    // Enabled event raises at once; clear through the clear register
    frame();
    `CHK("irq_event", 1'b1, o_irq)
    bus(1'b1, IDX_INTERRUPT_CLEAR, 8'h01, 4'hf);
    rd(IDX_INTERRUPT_FLAG, 8'h00, RESP_OK);
    `CHK("irq_clr_reg", 1'b0, o_irq)
    // Disabling with the flag still set drops the request
    frame();
    bus(1'b1, IDX_INTERRUPT_MASK, 8'h00, 4'hf);
    repeat (2) @(posedge i_clk);
    `CHK("irq_disabled", 1'b0, o_irq)
    rd(IDX_INTERRUPT_FLAG, 8'h01, RESP_OK);
    // Reset in mid-run brings everything back
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    mem = '{RST_DISPLAY_CONTROL, RST_CONTRAST_ADJUST, RST_DUTY_SELECT, RST_REGULATOR_CTRL,
            RST_POWER_BOOSTER};
    `CHK("ctrl_rerst", ctrl_of(), o_ctrl)
    rd(IDX_INTERRUPT_FLAG, 8'h00, RESP_OK);
    rd(IDX_INTERRUPT_MASK, 8'h00, RESP_OK);
    repeat (2) @(posedge i_clk);
    test_done();
  end
endmodule

bind lcdc_regs lcdc_regs_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .i_frame_sig(i_frame_sig), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
  .o_ctrl(o_ctrl), .o_irq(o_irq));
